// ===== ssrm_monitor.sv
// Speed range monitor with APB register access, start delay and optional tolerance range.
// Assumes speedIn and enable_request_in are synchronous to clk_sys.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`include "ssrm_regs.svh"

module ssrm_monitor #(
	parameter int MS_CYCLES = `SSRM_MS_CYCLES
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Speed feedback and activation.
	input wire ssrm_pkg::ssrm_speed_t speedIn,
	input wire logic enable_request_in,
	// Safety outputs.
	output ssrm_pkg::ssrm_out_s safetyOut
);
	import ssrm_pkg::*;

	ssrm_cfg_s cfg;
	ssrm_state_e state;
	ssrm_state_e next_state;
	ssrm_ms_t delayCount;
	ssrm_ms_t widthCount;
	ssrm_ms_t periodCount;
	logic tick;
	logic active;
	logic beyond;
	logic beyondPrev;
	logic beyondRise;
	logic ampOver;
	logic overshootSeen;
	logic violation;
	logic rangeOk;
	logic eStop;
	logic mapped;
	logic [31:0] readValue;

	function automatic ssrm_ms_t clampMs(input logic [31:0] v, input ssrm_ms_t lo);
		if (v < 32'(lo)) begin
			return lo;
		end
		if (v > 32'(`SSRM_MS_MAX)) begin
			return `SSRM_MS_MAX;
		end
		return v[16:0];
	endfunction : clampMs

	function automatic logic signed [39:0] absVal(input logic signed [39:0] v);
		return (v < 0) ? -v : v;
	endfunction : absVal

	// The bus answers in the access phase with no wait states.
	assign pready = 1'b1;
	assign mapped = (paddr <= `SSRM_OFF_SPEED) && (paddr[1:0] == 2'b00);
	assign pslverr = psel && penable && !mapped;

	// Configuration writes take effect at the access edge; delay and tolerance values are clamped to the legal ranges, ceiling and floor are not.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cfg.permanent <= 1'b0;
			cfg.monitorOnly <= 1'b0;
			cfg.tolEnable <= 1'b0;
			cfg.ceiling <= `SSRM_RST_CEILING;
			cfg.floor <= `SSRM_RST_FLOOR;
			cfg.delayMs <= `SSRM_RST_DELAY_MS;
			cfg.tolPct <= `SSRM_RST_TOL_PCT;
			cfg.overshootWidthMs <= `SSRM_RST_TOL_WIDTH_MS;
			cfg.oscillationPeriodMs <= `SSRM_RST_TOL_PERIOD_MS;
		end else if (psel && penable && pwrite) begin
			unique case (paddr)
				`SSRM_OFF_CTRL: begin
					cfg.permanent <= pwdata[`SSRM_CTRL_PERMANENT];
					cfg.monitorOnly <= pwdata[`SSRM_CTRL_MONITOR_ONLY];
					cfg.tolEnable <= pwdata[`SSRM_CTRL_TOL_ENABLE];
				end
				`SSRM_OFF_CEILING: begin
					cfg.ceiling <= pwdata[24:0];
				end
				`SSRM_OFF_FLOOR: begin
					cfg.floor <= pwdata[24:0];
				end
				`SSRM_OFF_DELAY: begin
					cfg.delayMs <= clampMs(pwdata, 17'h00000);
				end
				`SSRM_OFF_TOL_PCT: begin
					if (pwdata < 32'(`SSRM_TOL_PCT_MIN)) begin
						cfg.tolPct <= `SSRM_TOL_PCT_MIN;
					end else if (pwdata > 32'(`SSRM_TOL_PCT_MAX)) begin
						cfg.tolPct <= `SSRM_TOL_PCT_MAX;
					end else begin
						cfg.tolPct <= pwdata[4:0];
					end
				end
				`SSRM_OFF_TOL_WIDTH: begin
					cfg.overshootWidthMs <= clampMs(pwdata, `SSRM_TOL_WIDTH_MIN);
				end
				`SSRM_OFF_TOL_PERIOD: begin
					cfg.oscillationPeriodMs <= clampMs(pwdata, `SSRM_TOL_PERIOD_MIN);
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is captured in the setup phase so that it stands through the access phase.
	always_comb begin
		readValue = 32'h00000000;
		unique case (paddr)
			`SSRM_OFF_CTRL: begin
				readValue[`SSRM_CTRL_PERMANENT] = cfg.permanent;
				readValue[`SSRM_CTRL_MONITOR_ONLY] = cfg.monitorOnly;
				readValue[`SSRM_CTRL_TOL_ENABLE] = cfg.tolEnable;
			end
			`SSRM_OFF_CEILING: readValue = 32'(signed'(cfg.ceiling));
			`SSRM_OFF_FLOOR: readValue = 32'(signed'(cfg.floor));
			`SSRM_OFF_DELAY: readValue = 32'(cfg.delayMs);
			`SSRM_OFF_TOL_PCT: readValue = 32'(cfg.tolPct);
			`SSRM_OFF_TOL_WIDTH: readValue = 32'(cfg.overshootWidthMs);
			`SSRM_OFF_TOL_PERIOD: readValue = 32'(cfg.oscillationPeriodMs);
			`SSRM_OFF_STATUS: begin
				readValue[`SSRM_STAT_RANGE_OK] = rangeOk;
				readValue[`SSRM_STAT_ESTOP] = eStop;
				readValue[`SSRM_STAT_STATE_LSB +: 2] = state;
				readValue[`SSRM_STAT_BEYOND] = beyond;
				readValue[`SSRM_STAT_TOL_ACTIVE] = overshootSeen;
			end
			`SSRM_OFF_SPEED: readValue = 32'(signed'(speedIn));
			default: readValue = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= readValue;
		end
	end

	// The function is active when the input is low, or always in permanent mode.
	assign active = cfg.permanent || !enable_request_in;

	// Limit comparison and amplitude margin, worked in 40-bit signed arithmetic without a divider.
	always_comb begin
		logic signed [39:0] sp;
		logic signed [39:0] hi;
		logic signed [39:0] lo;
		logic signed [39:0] pct;
		sp = 40'(signed'(speedIn));
		hi = 40'(signed'(cfg.ceiling));
		lo = 40'(signed'(cfg.floor));
		pct = 40'(signed'({1'b0, cfg.tolPct}));
		beyond = (sp > hi) || (sp < lo);
		ampOver = ((sp - hi) * 40'sd100 > absVal(hi) * pct)
			|| ((lo - sp) * 40'sd100 > absVal(lo) * pct);
	end

	assign beyondRise = beyond && !beyondPrev;

	// With tolerance the plain crossing only opens the window; the margins decide.
	always_comb begin
		if (cfg.tolEnable) begin
			violation = ampOver
				|| (beyond && widthCount >= cfg.overshootWidthMs)
				|| (beyondRise && overshootSeen && periodCount < cfg.oscillationPeriodMs);
		end else begin
			violation = beyond;
		end
	end

	ssrm_ms_tick #(
		.CYCLES_PER_MS(MS_CYCLES)
	) msTick (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.restart(state != next_state),
		.tick(tick)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			SSRM_IDLE: begin
				if (active) begin
					if (cfg.permanent || cfg.delayMs == 17'h00000) begin
						next_state = SSRM_MONITOR;
					end else begin
						next_state = SSRM_DELAY;
					end
				end
			end
			SSRM_DELAY: begin
				if (!active) begin
					next_state = SSRM_IDLE;
				end else if (cfg.permanent || delayCount >= cfg.delayMs) begin
					next_state = SSRM_MONITOR;
				end
			end
			SSRM_MONITOR: begin
				if (!active) begin
					next_state = SSRM_IDLE;
				end else if (violation && !cfg.monitorOnly) begin
					next_state = SSRM_TRIPPED;
				end
			end
			SSRM_TRIPPED: begin
				if (!active) begin
					next_state = SSRM_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state <= SSRM_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Start delay counter in whole milliseconds.
	always_ff @(posedge clk_sys) begin
		if (!resetn || state != SSRM_DELAY) begin
			delayCount <= 17'h00000;
		end else if (tick && delayCount != `SSRM_MS_MAX) begin
			delayCount <= delayCount + 17'h00001;
		end
	end

	// Tolerance tracking: opened by the first crossing, then width and recurrence are timed.
	always_ff @(posedge clk_sys) begin
		if (!resetn || state != SSRM_MONITOR) begin
			beyondPrev <= 1'b0;
			overshootSeen <= 1'b0;
			widthCount <= 17'h00000;
			periodCount <= 17'h00000;
		end else begin
			beyondPrev <= beyond;
			if (beyondRise) begin
				overshootSeen <= 1'b1;
				periodCount <= 17'h00000;
			end else if (tick && periodCount != `SSRM_MS_MAX) begin
				periodCount <= periodCount + 17'h00001;
			end
			if (!beyond) begin
				widthCount <= 17'h00000;
			end else if (tick && widthCount != `SSRM_MS_MAX) begin
				widthCount <= widthCount + 17'h00001;
			end
		end
	end

	// Outputs come from flops; the stop follows the state being entered, the range flag needs monitoring in both cycles and no violation.
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			rangeOk <= 1'b0;
			eStop <= 1'b0;
		end else begin
			rangeOk <= (next_state == SSRM_MONITOR) && (state == SSRM_MONITOR) && !violation;
			eStop <= (next_state == SSRM_TRIPPED);
		end
	end

	assign safetyOut.rangeOkFlag = rangeOk;
	assign safetyOut.controlledEmergencyStop = eStop;

endmodule : ssrm_monitor

// ===== ssrm_monitor_assertions.sv
// Port checks of the speed range monitor.
// Assumes the activation input is not toggled while permanent mode is set.
module ssrm_monitor_assertions (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// APB.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Safety link.
	input wire logic enable_request_in,
	input wire ssrm_pkg::ssrm_out_s safetyOut
);
	import ssrm_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);
	logic badAddr;
	assign badAddr = (paddr > 8'h20) || (paddr[1:0] != 2'h0);
	a_stop_held:
		assert property (safetyOut.controlledEmergencyStop && !enable_request_in |=> safetyOut.controlledEmergencyStop)
		else $error("stop request released while active");
	a_stop_ok_low:
		assert property (safetyOut.controlledEmergencyStop |-> !safetyOut.rangeOkFlag)
		else $error("range flag high during stop");
	a_deact_clear:
		assert property ($rose(enable_request_in) |=> !safetyOut.rangeOkFlag && !safetyOut.controlledEmergencyStop)
		else $error("outputs not cleared on deactivation");
	a_delay_first:
		assert property ($fell(enable_request_in) |=> !safetyOut.rangeOkFlag)
		else $error("range flag high without start delay");
	a_prdata_hold:
		assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed outside a read setup");
	a_err_decode:
		assert property (psel && penable |-> pslverr == badAddr)
		else $error("wrong slave error");
	a_err_idle:
		assert property (!(psel && penable) |-> !pslverr)
		else $error("slave error outside access");
	a_err_rd_zero:
		assert property (psel && penable && !pwrite && badAddr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_ready_high:
		assert property (pready)
		else $error("ready low");
endmodule : ssrm_monitor_assertions

bind ssrm_monitor ssrm_monitor_assertions ssrm_monitor_assertions_i (.clk_sys, .resetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .enable_request_in, .safetyOut);

// ===== ssrm_ms_tick.sv
// Millisecond tick generator for the speed range monitor.
// Assumes clk_sys runs at the rate that CYCLES_PER_MS is derived from.
module ssrm_ms_tick #(
	parameter int CYCLES_PER_MS = 125000
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// Phase restart and tick.
	input wire logic restart,
	output logic tick
);
	localparam int CW = $clog2(CYCLES_PER_MS + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES_PER_MS - 1);

	logic [CW-1:0] phase;

	always_ff @(posedge clk_sys) begin
		if (!resetn || restart) begin
			phase <= '0;
		end else if (phase == LAST) begin
			phase <= '0;
		end else begin
			phase <= phase + CW'(1);
		end
	end

	assign tick = (phase == LAST) && !restart;

endmodule : ssrm_ms_tick

// ===== ssrm_pkg.sv
// Types shared by the speed range monitor modules.
// Assumes the register header is on the include path.
package ssrm_pkg;

	typedef logic signed [24:0] ssrm_speed_t;
	typedef logic [16:0] ssrm_ms_t;

	typedef enum logic [1:0] {
		SSRM_IDLE = 2'b00,
		SSRM_DELAY = 2'b01,
		SSRM_MONITOR = 2'b10,
		SSRM_TRIPPED = 2'b11
	} ssrm_state_e;

	typedef struct packed {
		logic permanent;
		logic monitorOnly;
		logic tolEnable;
		ssrm_speed_t ceiling;
		ssrm_speed_t floor;
		ssrm_ms_t delayMs;
		logic [4:0] tolPct;
		ssrm_ms_t overshootWidthMs;
		ssrm_ms_t oscillationPeriodMs;
	} ssrm_cfg_s;

	typedef struct packed {
		logic rangeOkFlag;
		logic controlledEmergencyStop;
	} ssrm_out_s;

endpackage : ssrm_pkg

// ===== ssrm_regs.svh
// Register offsets, field positions, reset values and timing counts of the speed range monitor.
// Assumes inclusion by bare name from the monitor module.
`ifndef SSRM_REGS_SVH
`define SSRM_REGS_SVH

`define SSRM_OFF_CTRL 8'h00
`define SSRM_OFF_CEILING 8'h04
`define SSRM_OFF_FLOOR 8'h08
`define SSRM_OFF_DELAY 8'h0c
`define SSRM_OFF_TOL_PCT 8'h10
`define SSRM_OFF_TOL_WIDTH 8'h14
`define SSRM_OFF_TOL_PERIOD 8'h18
`define SSRM_OFF_STATUS 8'h1c
`define SSRM_OFF_SPEED 8'h20

`define SSRM_CTRL_PERMANENT 0
`define SSRM_CTRL_MONITOR_ONLY 1
`define SSRM_CTRL_TOL_ENABLE 2

`define SSRM_STAT_RANGE_OK 0
`define SSRM_STAT_ESTOP 1
`define SSRM_STAT_STATE_LSB 2
`define SSRM_STAT_BEYOND 4
`define SSRM_STAT_TOL_ACTIVE 5

`define SSRM_RST_CEILING 25'h00186a0
`define SSRM_RST_FLOOR 25'h1fe7960
`define SSRM_RST_DELAY_MS 17'h00014
`define SSRM_RST_TOL_PCT 5'h01
`define SSRM_RST_TOL_WIDTH_MS 17'h00064
`define SSRM_RST_TOL_PERIOD_MS 17'h003e8

`define SSRM_TOL_PCT_MIN 5'h01
`define SSRM_TOL_PCT_MAX 5'h19
`define SSRM_MS_MAX 17'h1d4c0
`define SSRM_TOL_WIDTH_MIN 17'h00001
`define SSRM_TOL_PERIOD_MIN 17'h00002

`define SSRM_CLK_PERIOD_NS 8
`define SSRM_MS_NS 1000000
`define SSRM_MS_CYCLES (`SSRM_MS_NS / `SSRM_CLK_PERIOD_NS)

`endif

// ===== ssrm_speed_model.sv
// Drive side model: speed feedback and the routed activation line.
// Assumes the bench changes target and activate just after rising edges.
module ssrm_speed_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// Commands from the bench.
	input wire ssrm_pkg::ssrm_speed_t target,
	input wire logic activate,
	// Lines to the monitor.
	output ssrm_pkg::ssrm_speed_t speedIn,
	output logic enable_request_in
);
	import ssrm_pkg::*;
	always_ff @(posedge clk_sys) begin
		speedIn <= resetn ? target : '0;
	end
	always_ff @(posedge clk_sys) begin
		enable_request_in <= !(resetn && activate);
	end
endmodule : ssrm_speed_model

// ===== tb.sv
// Self-checking bench for the speed range monitor.
// Assumes the millisecond count is shortened to MSC cycles.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ssrm_pkg::*;
	localparam int MSC = 4;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, activate, err, enable_request_in;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] st = 32'h0000e64c;
	ssrm_speed_t speedIn, target;
	ssrm_out_s safetyOut;
	int numErrors, testsRun, i, c;
	logic [31:0] dflt[7] = '{32'h0, 32'h000186a0, 32'hfffe7960, 32'h14, 32'h1, 32'h64, 32'h3e8};
	logic [7:0] ca[4] = '{8'h10, 8'h14, 8'h18, 8'h0c};
	int cv[4] = '{30, 0, 1, 200000};
	int clo[4] = '{1, 1, 2, 0};
	ssrm_monitor #(.MS_CYCLES(MSC)) ssrm_monitor_i (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .speedIn, .enable_request_in, .safetyOut);
	ssrm_speed_model ssrm_speed_model_i (.clk_sys, .resetn, .target, .activate, .speedIn, .enable_request_in);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	function automatic int rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return int'(st % 32'd200001) - 100000;
	endfunction : rnd
	function automatic logic [31:0] clampv(int v, int lo, int hi);
		return (v < lo) ? lo : (v > hi) ? hi : v;
	endfunction : clampv
	function automatic logic trip(int s, int lim, int pct);
		return (s - lim) * 100 > lim * pct;
	endfunction : trip
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic hang();
		chk(32'h0, 32'h1);
		report_and_stop();
	endtask : hang
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc
	task automatic drive(input int s, input logic a);
		@(posedge clk_sys);
		target <= ssrm_speed_t'(s);
		activate <= a;
		#1;
	endtask : drive
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge clk_sys);
		end
		if (n == 16) hang();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_ok();
		for (c = 0; c < 4000 && safetyOut.rangeOkFlag !== 1'b1; c++) cyc(1);
		if (c == 4000) hang();
	endtask : wait_ok
	task automatic restart();
		drive(0, 1'b0);
		cyc(3);
		drive(0, 1'b1);
		wait_ok();
	endtask : restart
	initial begin
		{resetn, psel, penable, pwrite, activate, paddr, pwdata, target, numErrors, testsRun} = '0;
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		cyc(1);
		chk(safetyOut, 2'b00);
		for (i = 0; i < 7; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, dflt[i]);
		end
		apb(1'b0, 8'h24, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		apb(1'b1, 8'h06, 32'h1);
		chk(err, 1'b1);
		for (i = 0; i < 4; i++) begin
			apb(1'b1, ca[i], cv[i]);
			apb(1'b0, ca[i], 32'h0);
			chk(rd, clampv(cv[i], clo[i], 120000 - 120000 * (i == 0) + 25 * (i == 0)));
		end
		apb(1'b1, 8'h0c, 32'h2);
		drive(0, 1'b1);
		wait_ok();
		chk(c >= 2 * MSC && c <= 2 * MSC + 6, 1'b1);
		for (i = 0; i < 20; i++) begin
			drive((i == 0) ? 100000 : (i == 1) ? -100000 : rnd(), 1'b1);
			cyc(2);
			chk(safetyOut, 2'b10);
		end
		drive(100001, 1'b1);
		cyc(2);
		chk(safetyOut, 2'b01);
		apb(1'b0, 8'h1c, 32'h0);
		chk(rd, 32'h0000001e);
		apb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h000186a1);
		drive(0, 1'b1);
		cyc(4);
		chk(safetyOut, 2'b01);
		drive(0, 1'b0);
		cyc(3);
		chk(safetyOut, 2'b00);
		apb(1'b1, 8'h00, 32'h2);
		apb(1'b1, 8'h0c, 32'h0);
		restart();
		chk(c <= 4, 1'b1);
		drive(-100001, 1'b1);
		cyc(2);
		chk(safetyOut, 2'b00);
		drive(-100000, 1'b1);
		cyc(2);
		chk(safetyOut, 2'b10);
		apb(1'b1, 8'h00, 32'h4);
		apb(1'b1, 8'h10, 32'ha);
		apb(1'b1, 8'h14, 32'h3);
		apb(1'b1, 8'h18, 32'h32);
		restart();
		drive(105000, 1'b1);
		cyc(2);
		chk(safetyOut.controlledEmergencyStop, trip(105000, 100000, 10));
		drive(0, 1'b1);
		cyc(2);
		drive(105000, 1'b1);
		cyc(2);
		chk(safetyOut.controlledEmergencyStop, 1'b1);
		restart();
		drive(111000, 1'b1);
		cyc(2);
		chk(safetyOut.controlledEmergencyStop, trip(111000, 100000, 10));
		restart();
		drive(102000, 1'b1);
		cyc(2);
		chk(safetyOut.controlledEmergencyStop, 1'b0);
		cyc(5 * MSC);
		chk(safetyOut.controlledEmergencyStop, 1'b1);
		drive(200000, 1'b0);
		apb(1'b1, 8'h00, 32'h1);
		cyc(3);
		chk(safetyOut, 2'b01);
		apb(1'b1, 8'h00, 32'h0);
		cyc(2);
		chk(safetyOut, 2'b00);
		@(posedge clk_sys);
		resetn <= 1'b0;
		cyc(2);
		@(posedge clk_sys);
		resetn <= 1'b1;
		cyc(1);
		chk(safetyOut, 2'b00);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h00000001);
		report_and_stop();
	end
endmodule : tb
